//--- core/socp_parser.sv
`timescale 1ns/100ps
// Operation
// - a command is only the bytes between start-of-text and end-of-text
// - single-scan request is read-by-name type, space, scan data command
// - continuous request is event-by-name type, scan data command, start/stop flag
// - a valid scan data request starts measured-value output on the same link
// - read-by-name scan request returns exactly one telegram of the last scan
// - event request with flag 1 starts one telegram per scan completed outside a scan telegram
// - event request with flag 0 stops further measurement telegrams
// - after measurement start, ready state is reported only after settling
// - telegram order: config with time stamp, measured data, status with I/O
// - distance in mm by default; signal strength added only when enabled
module socp_parser
	import socp_pkg::*;
#(
	parameter int unsigned SETTLE_CYCLES = SOCP_SETTLE_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire socp_rx_t rx,
	input wire socp_point_t pt,
	input wire logic meas_start,
	input wire logic strength_en,
	input wire logic [7:0] dev_status,
	input wire logic [15:0] io_state,
	input wire logic tx_ready,
	output socp_tx_t tx,
	output logic cmd_err,
	output logic device_ready
);

	typedef enum logic {SOCP_RX_IDLE, SOCP_RX_BODY} socp_rx_st_t;
	typedef enum logic [1:0] {SOCP_TX_IDLE, SOCP_TX_SCAN, SOCP_TX_STATE} socp_tx_st_t;

	typedef struct packed {
		socp_rx_st_t rx_st;
		logic [8*SOCP_SEQ_BYTES-1:0] seq;
		logic [4:0] len;
		logic cont;
		logic pend_scan;
		logic pend_state;
		logic scan_ok;
		logic scan_new;
		logic [SOCP_POINTS-1:0][31:0] fill;
		logic [SOCP_POINTS-1:0][31:0] scan_mem;
		logic [2:0] fill_idx;
		logic [31:0] now;
		logic [31:0] stamp;
		logic [31:0] settle;
		logic ready;
		socp_tx_st_t tx_st;
		logic [2:0] tx_idx;
		logic strength_on;
		socp_tx_t tx;
		logic cmd_err;
	} socp_state_t;

	socp_state_t s_q;
	socp_state_t s_d;
	socp_cmd_t cmd;
	logic etx_hit;
	// a stop arriving as a continuous telegram would start wins over that start
	logic stop_hit;

	socp_matcher u_matcher (
		.seq(s_q.seq),
		.len(s_q.len),
		.cmd(cmd)
	);

	assign etx_hit = rx.valid && rx.data == SOCP_ETX && s_q.rx_st == SOCP_RX_BODY;
	assign stop_hit = etx_hit && cmd == SOCP_CMD_EVENT_STOP;

	function automatic logic [31:0] data_word(input logic [31:0] pnt, input logic on);
		data_word = on ? pnt : {16'h0000, pnt[15:0]};
	endfunction : data_word

	always_comb begin
		s_d = s_q;
		s_d.cmd_err = 1'b0;
		s_d.now = s_q.now + 32'h0000_0001;
		// telegram framing
		if (rx.valid) begin
			if (rx.data == SOCP_STX) begin
				s_d.rx_st = SOCP_RX_BODY;
				s_d.len = '0;
				s_d.seq = '0;
			end else if (s_q.rx_st == SOCP_RX_BODY && rx.data != SOCP_ETX) begin
				s_d.seq = {s_q.seq[8*SOCP_SEQ_BYTES-9:0], rx.data};
				s_d.len = (s_q.len == SOCP_LEN_MAX) ? SOCP_LEN_MAX : s_q.len + 5'h01;
			end
		end
		// telegram emission, cleared pendings may be set again below
		if (s_q.tx.valid && tx_ready) begin
			s_d.tx.valid = 1'b0;
			if (s_q.tx_st == SOCP_TX_SCAN) begin
				unique case (s_q.tx.section)
					SOCP_SEC_CONFIG: begin
						s_d.tx = '{1'b1, SOCP_SEC_DATA, data_word(s_q.scan_mem[0], s_q.strength_on), 1'b0};
						s_d.tx_idx = '0;
					end
					SOCP_SEC_DATA: begin
						if (s_q.tx_idx == SOCP_LAST_POINT) begin
							s_d.tx = '{1'b1, SOCP_SEC_STATUS, {7'h00, s_q.ready, dev_status, io_state}, 1'b1};
						end else begin
							s_d.tx_idx = s_q.tx_idx + 3'h1;
							s_d.tx = '{1'b1, SOCP_SEC_DATA,
								data_word(s_q.scan_mem[s_q.tx_idx + 3'h1], s_q.strength_on), 1'b0};
						end
					end
					default: s_d.tx_st = SOCP_TX_IDLE;
				endcase
			end else begin
				s_d.tx_st = SOCP_TX_IDLE;
			end
		end else if (s_q.tx_st == SOCP_TX_IDLE) begin
			if (s_q.pend_state) begin
				s_d.pend_state = 1'b0;
				s_d.tx_st = SOCP_TX_STATE;
				s_d.tx = '{1'b1, SOCP_SEC_STATE, {31'h0, s_q.ready}, 1'b1};
			end else if (s_q.scan_ok && (s_q.pend_scan || (s_q.cont && s_q.scan_new && !stop_hit))) begin
				s_d.pend_scan = 1'b0;
				s_d.scan_new = 1'b0;
				s_d.tx_st = SOCP_TX_SCAN;
				s_d.strength_on = strength_en;
				s_d.tx = '{1'b1, SOCP_SEC_CONFIG, s_q.stamp, 1'b0};
			end
		end
		// scan capture; a scan completed during a scan telegram is dropped
		// so is one completing as a telegram starts, so that stamp and points never mix
		if (pt.valid) begin
			s_d.fill[s_q.fill_idx] = {pt.strength, pt.dist_mm};
			s_d.fill_idx = s_q.fill_idx + 3'h1;
			if (pt.last || s_q.fill_idx == SOCP_LAST_POINT) begin
				s_d.fill_idx = '0;
				if (s_d.tx_st != SOCP_TX_SCAN) begin
					s_d.scan_mem = s_q.fill;
					s_d.scan_mem[s_q.fill_idx] = {pt.strength, pt.dist_mm};
					s_d.stamp = s_q.now;
					s_d.scan_ok = 1'b1;
					s_d.scan_new = s_q.cont;
				end
			end
		end
		// command decode at end-of-text
		if (etx_hit) begin
			s_d.rx_st = SOCP_RX_IDLE;
			unique case (cmd)
				SOCP_CMD_READ_SCAN: s_d.pend_scan = 1'b1;
				SOCP_CMD_EVENT_START: begin
					s_d.cont = 1'b1;
					s_d.scan_new = 1'b0;
				end
				SOCP_CMD_EVENT_STOP: begin
					s_d.cont = 1'b0;
					s_d.scan_new = 1'b0;
				end
				SOCP_CMD_STATE_QUERY: s_d.pend_state = 1'b1;
				default: s_d.cmd_err = 1'b1;
			endcase
		end
		// settling after measurement start
		if (meas_start) begin
			s_d.ready = 1'b0;
			s_d.settle = 32'(SETTLE_CYCLES);
		end else if (s_q.settle != '0) begin
			s_d.settle = s_q.settle - 32'h0000_0001;
			s_d.ready = (s_q.settle == 32'h0000_0001);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tx = s_q.tx;
	assign cmd_err = s_q.cmd_err;
	assign device_ready = s_q.ready;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	AST_FRAME_OPEN: assert property (rx.valid && rx.data == SOCP_STX |=> s_q.rx_st == SOCP_RX_BODY && s_q.len == '0)
		else $error("start byte did not open a frame");
	AST_READ_PEND: assert property (etx_hit && cmd == SOCP_CMD_READ_SCAN |=> s_q.pend_scan || s_q.tx_st == SOCP_TX_SCAN)
		else $error("single scan request lost");
	AST_EVENT_ON: assert property (etx_hit && cmd == SOCP_CMD_EVENT_START |=> s_q.cont)
		else $error("continuous output not started");
	AST_EVENT_OFF: assert property (stop_hit |=> !s_q.cont && !s_q.scan_new
		&& !(tx.valid && tx.section == SOCP_SEC_CONFIG && !$past(tx.valid) && !$past(s_q.pend_scan)))
		else $error("continuous output not stopped");
	AST_BAD_CMD: assert property (etx_hit && cmd == SOCP_CMD_NONE |=> cmd_err && !$rose(s_q.pend_scan) && $stable(s_q.cont))
		else $error("malformed command not flagged");
	AST_SETTLE: assert property ($rose(device_ready) |-> $past(s_q.settle) == 32'h0000_0001 && !$past(meas_start))
		else $error("ready reported before settling ended");
	AST_START_OUT: assert property (s_q.tx_st == SOCP_TX_IDLE && !s_q.pend_state && s_q.scan_ok && s_q.pend_scan
		&& !(s_q.tx.valid && tx_ready) |=> tx.valid && tx.section == SOCP_SEC_CONFIG && tx.word == $past(s_q.stamp))
		else $error("scan request did not start output");
	AST_ORDER_CFG: assert property (tx.valid && tx.section == SOCP_SEC_CONFIG && tx_ready |=> tx.valid && tx.section == SOCP_SEC_DATA)
		else $error("config section not followed by data");
	AST_ORDER_STAT: assert property (tx.valid && tx.section == SOCP_SEC_DATA && s_q.tx_idx == SOCP_LAST_POINT && tx_ready
		|=> tx.valid && tx.section == SOCP_SEC_STATUS && tx.last)
		else $error("data section not closed by status");
	AST_DIST_ONLY: assert property (tx.valid && tx.section == SOCP_SEC_DATA && !s_q.strength_on |-> tx.word[31:16] == 16'h0000)
		else $error("signal strength sent while disabled");
	AST_STATE_ANS: assert property (s_q.tx_st == SOCP_TX_IDLE && s_q.pend_state |=> tx.valid && tx.last
		&& tx.section == SOCP_SEC_STATE && tx.word[0] == $past(s_q.ready))
		else $error("device state answer wrong");
	AST_ERR_SRC: assert property (cmd_err |-> $past(etx_hit) && $past(cmd) == SOCP_CMD_NONE)
		else $error("error flag without malformed command");
	AST_OUTSIDE: assert property (rx.valid && rx.data != SOCP_STX && s_q.rx_st == SOCP_RX_IDLE
		|=> s_q.rx_st == SOCP_RX_IDLE && $stable(s_q.seq))
		else $error("byte outside a frame was taken");
	AST_ONE_TELEGRAM: assert property (tx.valid && tx.section == SOCP_SEC_STATUS && tx_ready |=> !tx.valid)
		else $error("telegram did not end after status");

endmodule : socp_parser

//--- core/socp_pkg.sv
package socp_pkg;

	localparam logic [7:0] SOCP_STX = 8'h02;
	localparam logic [7:0] SOCP_ETX = 8'h03;
	localparam logic [7:0] SOCP_FLAG_STOP = 8'h30;
	localparam logic [7:0] SOCP_FLAG_START = 8'h31;
	localparam int SOCP_SEQ_BYTES = 17;
	localparam logic [4:0] SOCP_LEN_READ_SCAN = 5'h0F;
	localparam logic [4:0] SOCP_LEN_EVENT_SCAN = 5'h11;
	localparam logic [4:0] SOCP_LEN_STATE_QUERY = 5'h11;
	localparam logic [4:0] SOCP_LEN_MAX = 5'h1F;
	// read-by-name type, space, scan data command
	localparam logic [119:0] SOCP_READ_SCAN_STR = 120'h73524E204C4D447363616E64617461;
	// event-by-name type, space, scan data command, space
	localparam logic [127:0] SOCP_EVENT_SCAN_PFX = 128'h73454E204C4D447363616E6461746120;
	// read-by-name type, space, device state query
	localparam logic [135:0] SOCP_STATE_QUERY_STR = 136'h73524E2053436465766963657374617465;
	localparam int SOCP_POINTS = 8;
	localparam logic [2:0] SOCP_LAST_POINT = 3'h7;
	localparam int SOCP_CLK_PERIOD_NS = 10;
	localparam int SOCP_SETTLE_TIME_NS = 1000000;
	localparam int SOCP_SETTLE_CYCLES = SOCP_SETTLE_TIME_NS / SOCP_CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		SOCP_CMD_NONE,
		SOCP_CMD_READ_SCAN,
		SOCP_CMD_EVENT_STOP,
		SOCP_CMD_EVENT_START,
		SOCP_CMD_STATE_QUERY
	} socp_cmd_t;

	typedef enum logic [1:0] {
		SOCP_SEC_CONFIG,
		SOCP_SEC_DATA,
		SOCP_SEC_STATUS,
		SOCP_SEC_STATE
	} socp_sec_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} socp_rx_t;

	typedef struct packed {
		logic valid;
		logic last;
		logic [15:0] dist_mm;
		logic [15:0] strength;
	} socp_point_t;

	typedef struct packed {
		logic valid;
		socp_sec_t section;
		logic [31:0] word;
		logic last;
	} socp_tx_t;

endpackage : socp_pkg

//--- core/socp_matcher.sv
`timescale 1ns/100ps
module socp_matcher
	import socp_pkg::*;
(
	input wire logic [8*SOCP_SEQ_BYTES-1:0] seq,
	input wire logic [4:0] len,
	output socp_cmd_t cmd
);

	always_comb begin
		cmd = SOCP_CMD_NONE;
		if (len == SOCP_LEN_READ_SCAN && seq[119:0] == SOCP_READ_SCAN_STR) begin
			cmd = SOCP_CMD_READ_SCAN;
		end else if (len == SOCP_LEN_EVENT_SCAN && seq[135:8] == SOCP_EVENT_SCAN_PFX) begin
			if (seq[7:0] == SOCP_FLAG_START) begin
				cmd = SOCP_CMD_EVENT_START;
			end else if (seq[7:0] == SOCP_FLAG_STOP) begin
				cmd = SOCP_CMD_EVENT_STOP;
			end
		end else if (len == SOCP_LEN_STATE_QUERY && seq == SOCP_STATE_QUERY_STR) begin
			cmd = SOCP_CMD_STATE_QUERY;
		end
	end

endmodule : socp_matcher

//--- testbench/socp_host_model.sv
`timescale 1ns/100ps
module socp_host_model
	import socp_pkg::*;
(
	input wire logic ref_clk,
	input wire socp_tx_t tx,
	input wire logic stall,
	output socp_rx_t rx,
	output logic tx_ready
);
	socp_tx_t got_q[$];
	logic ph_q = 1'b0;
	initial rx = '{1'b0, 8'hFF};
	// sink accepts on every other cycle while stalling
	assign tx_ready = ~stall | ph_q;
	always @(posedge ref_clk) begin
		ph_q <= ~ph_q;
		if (tx.valid && tx_ready)
			got_q.push_back(tx);
	end
	// framed command of n bytes, first byte in the top used byte of s
	task automatic send(input logic [8*SOCP_SEQ_BYTES-1:0] s, input int n);
		@(posedge ref_clk) rx <= '{1'b1, SOCP_STX};
		for (int i = n - 1; i >= 0; i--) @(posedge ref_clk) rx <= '{1'b1, s[8*i +: 8]};
		@(posedge ref_clk) rx <= '{1'b1, SOCP_ETX};
		@(posedge ref_clk) rx <= '{1'b0, ~SOCP_ETX};
	endtask : send
	task automatic raw(input logic [7:0] b);
		@(posedge ref_clk) rx <= '{1'b1, b};
		@(posedge ref_clk) rx <= '{1'b0, ~b};
	endtask : raw
endmodule : socp_host_model

//--- testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top
	import socp_pkg::*;
;
	localparam int SETTLE = 20;
	logic ref_clk, rst, meas_start, strength_en, stall, tx_ready, cmd_err, device_ready;
	logic [7:0] dev_status;
	logic [15:0] io_state;
	socp_point_t pt;
	socp_rx_t rx;
	socp_tx_t tx;
	socp_tx_t w;
	logic [31:0] last_stamp;
	int n_mismatch = 0;
	int n_compared = 0;
	int n_err = 0;
	socp_parser #(.SETTLE_CYCLES(SETTLE)) DUT (.ref_clk(ref_clk), .rst(rst), .rx(rx), .pt(pt),
		.meas_start(meas_start), .strength_en(strength_en), .dev_status(dev_status), .io_state(io_state),
		.tx_ready(tx_ready), .tx(tx), .cmd_err(cmd_err), .device_ready(device_ready));
	socp_host_model HOST (.ref_clk(ref_clk), .tx(tx), .stall(stall), .rx(rx), .tx_ready(tx_ready));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) if (cmd_err === 1'b1) n_err++;
	task automatic complete_run();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	task automatic chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk
	task automatic wait_words(input int n);
		for (int k = 0; k < 300 && HOST.got_q.size() < n; k++) @(posedge ref_clk);
		chk(HOST.got_q.size() == n, "word count");
	endtask : wait_words
	task automatic feed_scan(input logic [15:0] base);
		for (int i = 0; i < SOCP_POINTS; i++)
			@(posedge ref_clk) pt <= '{1'b1, i == SOCP_POINTS - 1, base + 16'(i), ~(base + 16'(i))};
		@(posedge ref_clk) pt <= '{1'b0, 1'b0, ~base, base};
	endtask : feed_scan
	task automatic check_scan(input logic [15:0] base, input logic str);
		socp_sec_t sec;
		logic [15:0] d;
		wait_words(SOCP_POINTS + 2);
		for (int i = 0; i < SOCP_POINTS + 2; i++) begin
			w = HOST.got_q.pop_front();
			if (i == 0)
				last_stamp = w.word;
			d = base + 16'(i - 1);
			sec = i == 0 ? SOCP_SEC_CONFIG : (i == SOCP_POINTS + 1 ? SOCP_SEC_STATUS : SOCP_SEC_DATA);
			chk(w.section === sec && w.last === (sec == SOCP_SEC_STATUS), "section order");
			if (sec == SOCP_SEC_DATA)
				chk(w.word === {str ? ~d : 16'h0000, d}, "point word");
			if (sec == SOCP_SEC_STATUS)
				chk(w.word === {7'h00, 1'b1, dev_status, io_state}, "status word");
		end
		repeat (30) @(posedge ref_clk);
		chk(HOST.got_q.size() == 0, "one telegram per request or scan");
	endtask : check_scan
	task automatic t_state(input logic rdy);
		HOST.send(SOCP_STATE_QUERY_STR, 17);
		wait_words(1);
		w = HOST.got_q.pop_front();
		chk(w.section === SOCP_SEC_STATE && w.word === {31'h0, rdy} && w.last === 1'b1, "state");
	endtask : t_state
	task automatic t_settle();
		@(posedge ref_clk) meas_start <= 1'b1;
		@(posedge ref_clk) meas_start <= 1'b0;
		repeat (SETTLE / 2) @(posedge ref_clk);
		chk(device_ready === 1'b0, "ready too early");
		repeat (SETTLE) @(posedge ref_clk);
		chk(device_ready === 1'b1, "ready missing");
	endtask : t_settle
	task automatic t_bad();
		HOST.send({8'h00, SOCP_READ_SCAN_STR[119:88], 8'h20, SOCP_READ_SCAN_STR[87:0]}, 16);
		HOST.send({SOCP_EVENT_SCAN_PFX, 8'h32}, 17);
		HOST.send({24'h000000, SOCP_READ_SCAN_STR[119:8]}, 14);
		HOST.raw(SOCP_ETX);
		repeat (10) @(posedge ref_clk);
		chk(n_err == 3 && HOST.got_q.size() == 0, "malformed refused");
	endtask : t_bad
	task automatic t_read(input logic [15:0] base, input logic str);
		feed_scan(base);
		HOST.send({16'h0000, SOCP_READ_SCAN_STR}, 15);
		check_scan(base, str);
	endtask : t_read
	task automatic t_cont();
		logic [31:0] st;
		HOST.send({SOCP_EVENT_SCAN_PFX, SOCP_FLAG_START}, 17);
		feed_scan(16'h0300);
		check_scan(16'h0300, 1'b1);
		st = last_stamp;
		feed_scan(16'h0400);
		check_scan(16'h0400, 1'b1);
		chk(last_stamp > st, "time stamp advances");
		HOST.send({SOCP_EVENT_SCAN_PFX, SOCP_FLAG_STOP}, 17);
		feed_scan(16'h0500);
		repeat (40) @(posedge ref_clk);
		chk(HOST.got_q.size() == 0, "output stopped");
	endtask : t_cont
	initial begin
		rst = 1'b1;
		pt = '0;
		meas_start = 1'b0;
		strength_en = 1'b0;
		stall = 1'b0;
		dev_status = 8'hA5;
		io_state = 16'h5AC3;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chk(tx.valid === 1'b0 && device_ready === 1'b0 && cmd_err === 1'b0, "reset outputs");
		t_state(1'b0);
		t_settle();
		t_state(1'b1);
		t_read(16'h0100, 1'b0);
		stall <= 1'b1;
		strength_en <= 1'b1;
		t_read(16'h0200, 1'b1);
		t_bad();
		t_cont();
		complete_run();
	end
	initial begin
		#200000;
		n_mismatch++;
		complete_run();
	end
endmodule : tb_top
